/* power_good_fault_pkg.sv */
package power_good_fault_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] COMP_H_REF_OFFSET   = 8'hE4;
  localparam logic [7:0] MASK_ONE_OFFSET     = 8'hE5;
  localparam logic [7:0] MASK_TWO_OFFSET     = 8'hE6;
  localparam logic [7:0] STATUS_ONE_OFFSET   = 8'hE7;
  localparam logic [7:0] STATUS_TWO_OFFSET   = 8'hE8;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] COMP_H_REF_RESET = 8'h00;
  localparam logic [7:0] MASK_ONE_RESET   = 8'h00;
  localparam logic [1:0] MASK_TWO_RESET   = 2'h0;
  localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
  localparam logic [4:0] STATUS_TWO_RESET = 5'h00;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int DISCHARGE_BIT   = 7;
  localparam int SHIFT_MSB       = 6;
  localparam int SHIFT_LSB       = 3;
  localparam int VSEL_MSB        = 2;
  localparam int VSEL_LSB        = 0;
  localparam int MASK_ONE_R13    = 0;
  localparam int MASK_TWO_R11    = 1;
  localparam int MASK_TWO_R12    = 0;
  localparam int STATUS_ONE_R13  = 7;
  localparam int STATUS_TWO_R12  = 4;
  localparam int STATUS_TWO_R11  = 3;
  localparam logic [5:0] MASK_TWO_RESERVED   = 6'h3F;
  localparam logic [2:0] STATUS_TWO_RESERVED = 3'h7;

  // ---------------------------------------------------------------
  // window voltage tables
  // ---------------------------------------------------------------
  typedef logic [12:0] millivolt_type;

  localparam int            DISCHARGE_OHMS     = 100;
  localparam logic [2:0]    VSEL_TOP_CODE      = 3'h7;
  localparam millivolt_type MV_TOP_HIGH        = 13'h1388;
  localparam millivolt_type SHIFT_THRESHOLD_MV = 13'h41A;
  localparam millivolt_type ALT_MODE_MV        = 13'h3E8;
  localparam logic [3:0]    ALT_CODE_COUNT     = 4'hA;
  localparam logic [3:0]    PERCENT_CODE_COUNT = 4'h8;
  localparam logic [6:0]    PERCENT_BASE       = 7'h64;
  localparam logic [19:0]   MV_TO_10UV         = 20'h00064;

  localparam millivolt_type NOMINAL_MV [8] = '{
    13'h3E8, 13'h4B0, 13'h5DC, 13'h708, 13'h44C, 13'h546, 13'hCE4, 13'h9C4
  };
  localparam millivolt_type ALT_MV [10] = '{
    13'h41A, 13'h3E8, 13'h3CF, 13'h3B6, 13'h384,
    13'h36B, 13'h352, 13'h320, 13'h2EE, 13'h2BC
  };
  localparam logic [4:0] SHIFT_PERCENT [8] = '{
    5'h03, 5'h02, 5'h01, 5'h00, 5'h1F, 5'h1E, 5'h1D, 5'h1C
  };

endpackage

/* reference_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface reference_if;
  logic       discharge;
  logic [3:0] shift;
  logic [2:0] vsel;

  modport bank    (output discharge, output shift, output vsel);
  modport decoder (input discharge, input shift, input vsel);
endinterface

`default_nettype wire

/* window_reference_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module window_reference_decode
  import power_good_fault_pkg::*;
#(
  parameter logic HIGH_CODE_IS_5V = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // fields from the register bank
  reference_if.decoder     ref_fields,
  // decoded window
  output logic      [12:0] nominal_mv,
  output logic      [19:0] target_10uv,
  output logic             alt_mode,
  output logic             code_valid
);

  logic [12:0] nominal_next;
  logic [19:0] target_next;
  logic        alt_next;
  logic        valid_next;
  logic [6:0]  factor;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    factor = PERCENT_BASE;
    if ((ref_fields.vsel == VSEL_TOP_CODE) && HIGH_CODE_IS_5V) begin
      nominal_next = MV_TOP_HIGH; // RULE4
    end else begin
      nominal_next = NOMINAL_MV[ref_fields.vsel]; // RULE4
    end
    alt_next    = (nominal_next == ALT_MODE_MV);
    valid_next  = 1'b0;
    target_next = 20'(nominal_next) * MV_TO_10UV;
    if (alt_next && (ref_fields.shift < ALT_CODE_COUNT)) begin
      target_next = 20'(ALT_MV[ref_fields.shift]) * MV_TO_10UV; // RULE3
      valid_next  = 1'b1;
    end else if ((nominal_next > SHIFT_THRESHOLD_MV) &&
                 (ref_fields.shift < PERCENT_CODE_COUNT)) begin
      factor      = 7'(PERCENT_BASE + 7'($signed(SHIFT_PERCENT[ref_fields.shift[2:0]])));
      target_next = 20'(nominal_next) * 20'(factor); // RULE2
      valid_next  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      nominal_mv  <= 13'h0000;
      target_10uv <= 20'h00000;
      alt_mode    <= 1'b0;
      code_valid  <= 1'b0;
    end else begin
      nominal_mv  <= nominal_next;
      target_10uv <= target_next;
      alt_mode    <= alt_next;
      code_valid  <= valid_next;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_shift_percent;
    @(posedge ref_clk) disable iff (!rstn)
      (ref_fields.vsel == 3'h3 && ref_fields.shift == 4'h0) |=> (target_10uv == 20'h2D438);
  endproperty
  a_shift_percent: assert property (p_shift_percent) // RULE2
    else $error("plus three percent wrong");

  property p_shift_minus;
    @(posedge ref_clk) disable iff (!rstn)
      (ref_fields.vsel == 3'h6 && ref_fields.shift == 4'h7) |=> (target_10uv == 20'h4D580);
  endproperty
  a_shift_minus: assert property (p_shift_minus) else $error("minus four percent wrong"); // RULE2

  property p_alt_level;
    @(posedge ref_clk) disable iff (!rstn)
      (ref_fields.vsel == 3'h0 && ref_fields.shift == 4'h9)
        |=> (target_10uv == 20'h11170 && alt_mode && code_valid);
  endproperty
  a_alt_level: assert property (p_alt_level) else $error("alternative level wrong"); // RULE3

  property p_nominal;
    @(posedge ref_clk) disable iff (!rstn)
      (ref_fields.vsel == 3'h5) |=> (nominal_mv == 13'h546 && !alt_mode);
  endproperty
  a_nominal: assert property (p_nominal) else $error("nominal voltage wrong"); // RULE4

endmodule

`default_nettype wire

/* power_good_fault_registers.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1: bit 7 of comparator h reference enables the 100 ohm discharge path.
// RULE2: above 1.05 V the shift field offsets the window +3 to -4 percent.
// RULE3: at 1 V the shift field picks alternative levels 1.05 down to 0.7 V.
// RULE4: voltage select picks the window nominal voltage, top code 2.5 or 5 V.
// RULE5: first mask register holds rails 4 to 10 and rail 13, one masks.
// RULE6: second mask register holds rail 11 in bit 1, rail 12 in bit 0.
// RULE7: reserved upper bits of second mask and second status read as ones.
// RULE8: first status register reports rail 13 and rails 10 to 4, read only.
// RULE9: second status reports rails 12, 11 and switched rails 11, 8, 6.
// RULE10: writes to status registers do nothing; status follows the rails.
// RULE11: a masked rail reports no fault onward but its status still updates.

module power_good_fault_registers
  import power_good_fault_pkg::*;
#(
  parameter logic HIGH_CODE_IS_5V = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,

  // register port from the serial bus slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,

  // rail monitoring
  input  wire logic [13:4] rail_good_in,
  input  wire logic [2:0]  rail_switched_good_in,
  input  wire logic [13:4] rail_fault_in,
  output logic      [13:4] rail_fault_report,

  // comparator h reference fields
  output logic             comparator_h_discharge_enable,
  output logic      [3:0]  comparator_h_window_shift,
  output logic      [2:0]  comparator_h_voltage_select,

  // decoded comparator h window
  output logic      [12:0] window_nominal_mv,
  output logic      [19:0] window_target_10uv,
  output logic             window_alt_mode,
  output logic             window_code_valid
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  comp_h_ref_reg;
  logic [7:0]  comp_h_ref_next;
  logic [7:0]  mask_one_reg;
  logic [7:0]  mask_one_next;
  logic [1:0]  mask_two_reg;
  logic [1:0]  mask_two_next;
  logic [7:0]  status_one_reg;
  logic [7:0]  status_one_next;
  logic [4:0]  status_two_reg;
  logic [4:0]  status_two_next;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic [13:4] fault_report_reg;
  logic [13:4] fault_report_next;
  logic [13:4] mask_by_rail;

  reference_if ref_fields ();

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_comb begin
    comp_h_ref_next = comp_h_ref_reg;
    mask_one_next   = mask_one_reg;
    mask_two_next   = mask_two_reg;
    if (reg_wr_en) begin
      if (reg_addr == COMP_H_REF_OFFSET) begin
        comp_h_ref_next = reg_wr_data; // RULE1
      end else if (reg_addr == MASK_ONE_OFFSET) begin
        mask_one_next = reg_wr_data; // RULE5
      end else if (reg_addr == MASK_TWO_OFFSET) begin
        mask_two_next = reg_wr_data[1:0]; // RULE6
      end
      // status offsets and unmapped offsets take no write
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      comp_h_ref_reg <= COMP_H_REF_RESET;
      mask_one_reg   <= MASK_ONE_RESET;
      mask_two_reg   <= MASK_TWO_RESET;
    end else begin
      comp_h_ref_reg <= comp_h_ref_next;
      mask_one_reg   <= mask_one_next;
      mask_two_reg   <= mask_two_next;
    end
  end

  // ---------------------------------------------------------------
  // power good status, sampled every cycle
  // ---------------------------------------------------------------
  always_comb begin
    status_one_next = {rail_good_in[13], rail_good_in[10:4]}; // RULE8
    status_two_next = {rail_good_in[12], rail_good_in[11], rail_switched_good_in}; // RULE9
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      status_one_reg <= STATUS_ONE_RESET;
      status_two_reg <= STATUS_TWO_RESET;
    end else begin
      status_one_reg <= status_one_next; // RULE10
      status_two_reg <= status_two_next; // RULE10
    end
  end

  // ---------------------------------------------------------------
  // fault gating per rail
  // ---------------------------------------------------------------
  assign mask_by_rail[13] = mask_one_reg[MASK_ONE_R13];
  assign mask_by_rail[12] = mask_two_reg[MASK_TWO_R12];
  assign mask_by_rail[11] = mask_two_reg[MASK_TWO_R11];

  genvar rail;
  generate
    for (rail = 4; rail <= 10; rail++) begin : g_mask_one
      assign mask_by_rail[rail] = mask_one_reg[11 - rail]; // RULE5
    end
  endgenerate

  always_comb begin
    fault_report_next = rail_fault_in & ~mask_by_rail; // RULE11
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fault_report_reg <= 10'h000;
    end else begin
      fault_report_reg <= fault_report_next;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_comb begin
    rd_data_next = rd_data_reg;
    if (reg_rd_en) begin
      if (reg_addr == COMP_H_REF_OFFSET) begin
        rd_data_next = comp_h_ref_reg;
      end else if (reg_addr == MASK_ONE_OFFSET) begin
        rd_data_next = mask_one_reg;
      end else if (reg_addr == MASK_TWO_OFFSET) begin
        rd_data_next = {MASK_TWO_RESERVED, mask_two_reg}; // RULE7
      end else if (reg_addr == STATUS_ONE_OFFSET) begin
        rd_data_next = status_one_reg;
      end else if (reg_addr == STATUS_TWO_OFFSET) begin
        rd_data_next = {STATUS_TWO_RESERVED, status_two_reg}; // RULE7
      end else begin
        rd_data_next = UNMAPPED_READ_VALUE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs and window decode
  // ---------------------------------------------------------------
  assign ref_fields.discharge = comp_h_ref_reg[DISCHARGE_BIT];
  assign ref_fields.shift     = comp_h_ref_reg[SHIFT_MSB:SHIFT_LSB];
  assign ref_fields.vsel      = comp_h_ref_reg[VSEL_MSB:VSEL_LSB];

  assign comparator_h_discharge_enable = comp_h_ref_reg[DISCHARGE_BIT]; // RULE1
  assign comparator_h_window_shift     = comp_h_ref_reg[SHIFT_MSB:SHIFT_LSB];
  assign comparator_h_voltage_select   = comp_h_ref_reg[VSEL_MSB:VSEL_LSB];
  assign rail_fault_report             = fault_report_reg;
  assign reg_rd_data                   = rd_data_reg;

  window_reference_decode #(
    .HIGH_CODE_IS_5V (HIGH_CODE_IS_5V)
  ) u_decode (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .ref_fields  (ref_fields.decoder),
    .nominal_mv  (window_nominal_mv),
    .target_10uv (window_target_10uv),
    .alt_mode    (window_alt_mode),
    .code_valid  (window_code_valid)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_discharge;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr_en && reg_addr == COMP_H_REF_OFFSET)
        |=> (comparator_h_discharge_enable == $past(reg_wr_data[7]));
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge enable not written"); // RULE1

  property p_mask_one_readback;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr_en && reg_addr == MASK_ONE_OFFSET) ##1 !reg_wr_en
        ##1 (reg_rd_en && reg_addr == MASK_ONE_OFFSET && !reg_wr_en)
        |=> (reg_rd_data == $past(reg_wr_data, 3));
  endproperty
  a_mask_one_readback: assert property (p_mask_one_readback) // RULE5
    else $error("mask one readback wrong");

  property p_rail4_masked;
    @(posedge ref_clk) disable iff (!rstn)
      (mask_one_reg[7] && rail_fault_in[4]) |=> !rail_fault_report[4];
  endproperty
  a_rail4_masked: assert property (p_rail4_masked) // RULE11
    else $error("masked rail 4 fault passed");

  property p_rail4_unmasked;
    @(posedge ref_clk) disable iff (!rstn)
      (!mask_one_reg[7] && rail_fault_in[4]) |=> rail_fault_report[4];
  endproperty
  a_rail4_unmasked: assert property (p_rail4_unmasked) // RULE5
    else $error("unmasked rail 4 fault lost");

  property p_rail11_mask;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr_en && reg_addr == MASK_TWO_OFFSET && reg_wr_data[1])
        ##1 (rail_fault_in[11] && !reg_wr_en) |=> !rail_fault_report[11];
  endproperty
  a_rail11_mask: assert property (p_rail11_mask) else $error("rail 11 mask not applied"); // RULE6

  property p_mask_two_reserved;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_rd_en && reg_addr == MASK_TWO_OFFSET) |=> (reg_rd_data[7:2] == 6'h3F);
  endproperty
  a_mask_two_reserved: assert property (p_mask_two_reserved) // RULE7
    else $error("mask two reserved not ones");

  property p_status_two_reserved;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_rd_en && reg_addr == STATUS_TWO_OFFSET) |=> (reg_rd_data[7:5] == 3'h7);
  endproperty
  a_status_two_reserved: assert property (p_status_two_reserved) // RULE7
    else $error("status two reserved not ones");

  property p_status_one_read;
    @(posedge ref_clk) disable iff (!rstn)
      (rstn && reg_rd_en && reg_addr == STATUS_ONE_OFFSET) ##0 $past(rstn)
        |=> (reg_rd_data == {$past(rail_good_in[13], 2), $past(rail_good_in[10:4], 2)});
  endproperty
  a_status_one_read: assert property (p_status_one_read) // RULE8
    else $error("status one mapping wrong");

  property p_status_two_track;
    @(posedge ref_clk) disable iff (!rstn)
      $past(rstn) |-> (status_two_reg == {$past(rail_good_in[12]), $past(rail_good_in[11]),
                                          $past(rail_switched_good_in)});
  endproperty
  a_status_two_track: assert property (p_status_two_track) // RULE9
    else $error("status two mapping wrong");

  property p_status_write_ignored;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr_en && reg_addr == STATUS_ONE_OFFSET && $past(rstn))
        |=> (status_one_reg == {$past(rail_good_in[13]), $past(rail_good_in[10:4])});
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) // RULE10
    else $error("status write took effect");

  property p_rail13_masked;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr_en && reg_addr == MASK_ONE_OFFSET && reg_wr_data[MASK_ONE_R13])
        ##1 (rail_fault_in[13] && !reg_wr_en) |=> !rail_fault_report[13];
  endproperty
  a_rail13_masked: assert property (p_rail13_masked) // RULE5
    else $error("rail 13 mask not applied");

  property p_rail12_unmasked;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_wr_en && reg_addr == MASK_TWO_OFFSET && !reg_wr_data[MASK_TWO_R12])
        ##1 (rail_fault_in[12] && !reg_wr_en) |=> rail_fault_report[12];
  endproperty
  a_rail12_unmasked: assert property (p_rail12_unmasked) // RULE6
    else $error("unmasked rail 12 fault lost");

  property p_status_two_read;
    @(posedge ref_clk) disable iff (!rstn)
      (reg_rd_en && reg_addr == STATUS_TWO_OFFSET) ##0 $past(rstn)
        |=> (reg_rd_data[4:0] == {$past(rail_good_in[12], 2), $past(rail_good_in[11], 2),
                                  $past(rail_switched_good_in, 2)});
  endproperty
  a_status_two_read: assert property (p_status_two_read) // RULE9
    else $error("status two read wrong");

  property p_reset_clears;
    @(posedge ref_clk)
      !rstn |=> (reg_rd_data == 8'h00 && rail_fault_report == 10'h000 &&
                 status_one_reg == STATUS_ONE_RESET && !comparator_h_discharge_enable);
  endproperty
  a_reset_clears: assert property (p_reset_clears) // RULE8
    else $error("reset left state behind");

endmodule

`default_nettype wire

/* power_good_host.sv */
`timescale 1ns/1ps
`default_nettype none

module power_good_host (
  // clock
  input  wire logic       ref_clk,
  // register strobe port
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en
);
  initial begin
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
  end

  // ---------------------------------------------------------------
  // one access: strobe held for one edge, then lines scrambled
  // ---------------------------------------------------------------
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(posedge ref_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= wr;
    reg_rd_en   <= !wr;
    @(posedge ref_clk);
    reg_wr_en   <= 1'b0;
    reg_rd_en   <= 1'b0;
    reg_addr    <= ~a;
    reg_wr_data <= ~d;
  endtask
endmodule

`default_nettype wire

/* test_power_good_fault_registers.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

module test_power_good_fault_registers;
  import power_good_fault_pkg::*;

  logic        ref_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wr_data;
  logic        reg_rd_en;
  logic [7:0]  reg_rd_data;
  logic [13:4] rail_good_in;
  logic [2:0]  rail_switched_good_in;
  logic [13:4] rail_fault_in;
  logic [13:4] rail_fault_report;
  logic        comparator_h_discharge_enable;
  logic [3:0]  comparator_h_window_shift;
  logic [2:0]  comparator_h_voltage_select;
  logic [12:0] window_nominal_mv;
  logic [19:0] window_target_10uv;
  logic        window_alt_mode;
  logic        window_code_valid;
  logic [7:0]  exp_q [$];
  logic [7:0]  exp_rd;
  logic [12:0] nom_high_mv;
  logic        rd_seen;
  logic [31:0] seed = 32'hECBA9AB7;
  logic [7:0]  m1;
  logic [1:0]  m2;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          nom_mv [8] = '{1000, 1200, 1500, 1800, 1100, 1350, 3300, 2500};
  int          alt_mv [10] = '{1050, 1000, 975, 950, 900, 875, 850, 800, 750, 700};

  power_good_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));

  power_good_fault_registers DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .rail_good_in(rail_good_in),
    .rail_switched_good_in(rail_switched_good_in), .rail_fault_in(rail_fault_in),
    .rail_fault_report(rail_fault_report),
    .comparator_h_discharge_enable(comparator_h_discharge_enable),
    .comparator_h_window_shift(comparator_h_window_shift),
    .comparator_h_voltage_select(comparator_h_voltage_select),
    .window_nominal_mv(window_nominal_mv), .window_target_10uv(window_target_10uv),
    .window_alt_mode(window_alt_mode), .window_code_valid(window_code_valid));

  // second build with the top select code meaning 5 V
  power_good_fault_registers #(.HIGH_CODE_IS_5V(1'b1)) DUT_HIGH (.ref_clk(ref_clk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(), .rail_good_in(rail_good_in),
    .rail_switched_good_in(rail_switched_good_in), .rail_fault_in(rail_fault_in),
    .rail_fault_report(), .comparator_h_discharge_enable(), .comparator_h_window_shift(),
    .comparator_h_voltage_select(), .window_nominal_mv(nom_high_mv), .window_target_10uv(),
    .window_alt_mode(), .window_code_valid());

  always #2 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  function automatic logic [13:4] fault_exp(input logic [13:4] f, input logic [7:0] a,
                                            input logic [1:0] b);
    return f & ~{a[0], b[0], b[1], a[1], a[2], a[3], a[4], a[5], a[6], a[7]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // read data watcher and timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    rd_seen <= rstn && reg_rd_en;
    if (rd_seen) begin
      exp_rd = exp_q.pop_front();
      `CHK("read data", exp_rd, reg_rd_data)
    end
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    rail_good_in = '0;
    rail_switched_good_in = '0;
    rail_fault_in = '0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'hE4, 8'h00);
    rd(8'hE5, 8'h00);
    rd(8'hE6, 8'hFC);
    rd(8'hE7, 8'h00);
    rd(8'hE8, 8'hE0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      m1 = seed[7:0];
      m2 = seed[9:8];
      wr(8'hE5, m1);
      rd(8'hE5, m1);
      wr(8'hE6, {seed[15:10], m2});
      rail_fault_in <= seed[25:16];
      rd(8'hE6, {6'h3F, m2});
      settle();
      `CHK("fault report", fault_exp(seed[25:16], m1, m2), rail_fault_report)
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      @(posedge ref_clk);
      rail_good_in <= seed[9:0];
      rail_switched_good_in <= seed[12:10];
      wr(8'hE7, seed[20:13]);
      wr(8'hE8, seed[28:21]);
      rd(8'hE7, {seed[9], seed[6:0]});
      rd(8'hE8, {3'h7, seed[8], seed[7], seed[12:10]});
    end
    wr(8'hE4, 8'h5A);
    wr(8'hE9, 8'hFF);
    rd(8'hE9, 8'h00);
    rd(8'hE3, 8'h00);
    rd(8'hE4, 8'h5A);
    for (int v = 0; v < 8; v++) begin
      wr(8'hE4, {v[0], 4'h3, v[2:0]});
      rd(8'hE4, {v[0], 4'h3, v[2:0]});
      settle();
      `CHK("discharge", v[0], comparator_h_discharge_enable)
      `CHK("vsel", v[2:0], comparator_h_voltage_select)
      `CHK("nominal", 13'(nom_mv[v]), window_nominal_mv)
      `CHK("nominal high", 13'(v == 7 ? 5000 : nom_mv[v]), nom_high_mv)
      `CHK("alt mode", 1'(v == 0), window_alt_mode)
      `CHK("target", 20'(v == 0 ? 95000 : nom_mv[v] * 100), window_target_10uv)
    end
    for (int c = 0; c < 16; c++) begin
      wr(8'hE4, {1'b0, c[3:0], 3'h5});
      settle();
      `CHK("shift", c[3:0], comparator_h_window_shift)
      `CHK("valid", 1'(c < 8), window_code_valid)
      `CHK("target", 20'(c < 8 ? 1350 * (103 - c) : 135000), window_target_10uv)
      wr(8'hE4, {1'b1, c[3:0], 3'h0});
      settle();
      `CHK("valid", 1'(c < 10), window_code_valid)
      `CHK("target", 20'(c < 10 ? alt_mv[c] * 100 : 100000), window_target_10uv)
    end
    wr(8'hE4, 8'h03);
    settle();
    `CHK("target", 20'(1800 * 103), window_target_10uv)
    wr(8'hE4, 8'h3E);
    settle();
    `CHK("target", 20'(3300 * 96), window_target_10uv)
    @(posedge ref_clk);
    rstn <= 1'b0;
    settle();
    `CHK("discharge", 1'b0, comparator_h_discharge_enable)
    `CHK("fault report", 10'h000, rail_fault_report)
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'hE4, 8'h00);
    rd(8'hE6, 8'hFC);
    settle();
    stop_test();
  end
endmodule

`default_nettype wire
